/* char_disp_decoder.sv */
// instruction decoder of the character display controller
`timescale 1ns/1ps
module char_disp_decoder #(
  parameter int unsigned CLEAR_CYCLES = char_disp_pkg::CLEAR_CYCLES,
  parameter int unsigned EXEC_TICKS = char_disp_pkg::EXEC_TICKS
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instrDataSelect,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [char_disp_pkg::DATA_W-1:0] wrData,
  output logic [char_disp_pkg::DATA_W-1:0] rdData,
  output logic busyFlag,
  output logic [char_disp_pkg::DISP_AW-1:0] addressCounter,
  output logic patternSelect,
  output char_disp_pkg::dispCfg_t dispCfg
);

  // ***************************************************************
  // state and helpers
  // ***************************************************************
  char_disp_pkg::decRegs_t q;
  char_disp_pkg::decRegs_t d;

  logic tick;
  logic memWe;
  logic [char_disp_pkg::MEM_AW-1:0] memWAddr;
  logic [char_disp_pkg::DATA_W-1:0] memWData;
  logic [char_disp_pkg::MEM_AW-1:0] memRAddr;
  logic [char_disp_pkg::DATA_W-1:0] memRData;
  logic [3:0] op;

  // next address after one step, kept inside the selected RAM
  function automatic logic [6:0] stepAddr(input logic [6:0] a,
                                          input logic inc,
                                          input logic pat);
    logic [6:0] n;
    n = inc ? a + 7'h01 : a - 7'h01;
    if (pat) begin
      n = {1'b0, n[5:0]};
    end
    return n;
  endfunction

  // memory index: display RAM low half, pattern RAM high half
  function automatic logic [7:0] memIndex(input logic [6:0] a,
                                          input logic pat);
    logic [7:0] m;
    m = pat ? {2'b10, a[5:0]} : {1'b0, a};
    return m;
  endfunction

  // ***************************************************************
  // submodules
  // ***************************************************************
  osc_tick #(
    .DIV(char_disp_pkg::OSC_DIV)
  ) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick)
  );

  disp_mem #(
    .AW(char_disp_pkg::MEM_AW),
    .DW(char_disp_pkg::DATA_W)
  ) u_mem (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .we(memWe),
    .wAddr(memWAddr),
    .wData(memWData),
    .rAddr(memRAddr),
    .rData(memRData)
  );

  // the memory follows the address counter so a read answers in one cycle
  assign memRAddr = memIndex(q.addressCounter, q.patternSel);
  assign op = char_disp_pkg::msbPos(wrData);

  // ***************************************************************
  // next state
  // ***************************************************************
  always_comb begin
    d = q;
    memWe = 1'b0;
    memWAddr = memIndex(q.addressCounter, q.patternSel);
    memWData = wrData;

    // status reads answer in every state, data reads return memory only in the idle state
    if (rdStrobe) begin
      if (!instrDataSelect) begin
        d.rdData = {q.busyFlag, q.addressCounter};
      end else if (q.st == char_disp_pkg::ST_IDLE) begin
        d.rdData = memRData;
        d.pendStep = 1'b1;
        d.pendShift = q.cfg.entryShift;
        d.busyFlag = 1'b1;
        d.cnt = char_disp_pkg::CNT_W'(EXEC_TICKS);
        d.st = char_disp_pkg::ST_EXEC;
      end else begin
        d.rdData = 8'h00;
      end
    end

    case (q.st)
      char_disp_pkg::ST_IDLE: begin
        if (wrStrobe && instrDataSelect) begin
          memWe = 1'b1;
          d.pendStep = 1'b1;
          d.pendShift = q.cfg.entryShift;
          d.busyFlag = 1'b1;
          d.cnt = char_disp_pkg::CNT_W'(EXEC_TICKS);
          d.st = char_disp_pkg::ST_EXEC;
        end else if (wrStrobe) begin
          d.pendStep = 1'b0;
          d.pendShift = 1'b0;
          d.busyFlag = 1'b1;
          d.cnt = char_disp_pkg::CNT_W'(EXEC_TICKS);
          d.st = char_disp_pkg::ST_EXEC;
          case (op)
            4'(char_disp_pkg::OP_CLEAR): begin
              d.addressCounter = '0;
              d.patternSel = 1'b0;
              d.cfg.shiftOffset = '0;
              d.clrAddr = '0;
              d.clrDone = 1'b0;
              d.cnt = char_disp_pkg::CNT_W'(CLEAR_CYCLES - 1);
              d.st = char_disp_pkg::ST_CLEAR;
            end
            4'(char_disp_pkg::OP_HOME): begin
              // the low bit is a test input and plays no part here
              d.addressCounter = '0;
              d.patternSel = 1'b0;
              d.cfg.shiftOffset = '0;
            end
            4'(char_disp_pkg::OP_ENTRY): begin
              d.cfg.entryInc = wrData[char_disp_pkg::ENTRY_ID_BIT];
              d.cfg.entryShift = wrData[char_disp_pkg::ENTRY_S_BIT];
            end
            4'(char_disp_pkg::OP_DISPCTL): begin
              d.cfg.displayOn = wrData[char_disp_pkg::DISP_ON_BIT];
              d.cfg.cursorOn = wrData[char_disp_pkg::CUR_ON_BIT];
              d.cfg.blinkOn = wrData[char_disp_pkg::BLINK_BIT];
            end
            4'(char_disp_pkg::OP_SHIFT): begin
              if (wrData[1:0] == char_disp_pkg::SUB_MODE) begin
                // zero selects character mode, one graphic mode
                d.cfg.graphicMode = wrData[char_disp_pkg::MODE_GC_BIT];
                d.cfg.powerOn = wrData[char_disp_pkg::MODE_PWR_BIT];
              end else if (wrData[1:0] == char_disp_pkg::SUB_SHIFT) begin
                if (wrData[char_disp_pkg::SHIFT_SC_BIT]) begin
                  d.cfg.shiftOffset = stepAddr(q.cfg.shiftOffset,
                    wrData[char_disp_pkg::SHIFT_RL_BIT], 1'b0);
                end else begin
                  d.addressCounter = stepAddr(q.addressCounter,
                    wrData[char_disp_pkg::SHIFT_RL_BIT],
                    q.patternSel);
                end
              end
            end
            4'(char_disp_pkg::OP_FUNC): begin
              d.cfg.busWidthSelect = wrData[char_disp_pkg::FS_DL_BIT];
              d.cfg.lineCount = wrData[char_disp_pkg::FS_N_BIT];
              d.cfg.fontSel = wrData[char_disp_pkg::FS_F_BIT];
              d.cfg.fontTableHi = wrData[char_disp_pkg::FS_FTHI_BIT];
              d.cfg.fontTableLo = wrData[char_disp_pkg::FS_FTLO_BIT];
            end
            4'(char_disp_pkg::OP_PATADDR): begin
              d.addressCounter = {1'b0, wrData[5:0]};
              d.patternSel = 1'b1;
            end
            4'(char_disp_pkg::OP_DISPADDR): begin
              d.addressCounter = wrData[6:0];
              d.patternSel = 1'b0;
            end
            default: begin
              // all-zero byte: nothing to execute
              d.busyFlag = 1'b0;
              d.st = char_disp_pkg::ST_IDLE;
            end
          endcase
        end
      end

      char_disp_pkg::ST_CLEAR: begin
        // blank every display location while the clear time counts down from the same start
        memWe = !q.clrDone;
        memWAddr = {1'b0, q.clrAddr};
        memWData = char_disp_pkg::BLANK_CODE;
        d.clrAddr = q.clrAddr + 7'h01;
        if (q.clrAddr == char_disp_pkg::DISP_TOP) begin
          d.clrDone = 1'b1;
        end
        if (q.cnt == '0) begin
          d.busyFlag = 1'b0;
          d.st = char_disp_pkg::ST_IDLE;
        end else begin
          d.cnt = q.cnt - 1'b1;
        end
      end

      char_disp_pkg::ST_EXEC: begin
        if (tick) begin
          if (q.cnt <= char_disp_pkg::CNT_W'(1)) begin
            // the stepped address appears together with busy clearing
            if (q.pendStep) begin
              d.addressCounter = stepAddr(q.addressCounter,
                q.cfg.entryInc, q.patternSel);
            end
            if (q.pendShift) begin
              d.cfg.shiftOffset = stepAddr(q.cfg.shiftOffset,
                q.cfg.entryInc, 1'b0);
            end
            d.pendStep = 1'b0;
            d.pendShift = 1'b0;
            d.busyFlag = 1'b0;
            d.st = char_disp_pkg::ST_IDLE;
          end else begin
            d.cnt = q.cnt - 1'b1;
          end
        end
      end

      default: begin
        d.busyFlag = 1'b0;
        d.st = char_disp_pkg::ST_IDLE;
      end
    endcase
  end

  // ***************************************************************
  // registers
  // ***************************************************************
  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
      q.st <= char_disp_pkg::ST_IDLE;
      q.cfg.entryInc <= char_disp_pkg::RST_ENTRY_INC;
      q.cfg.busWidthSelect <= char_disp_pkg::RST_BUS_WIDTH;
      q.cfg.powerOn <= char_disp_pkg::RST_POWER_ON;
    end else begin
      q <= d;
    end
  end

  assign rdData = q.rdData;
  assign busyFlag = q.busyFlag;
  assign addressCounter = q.addressCounter;
  assign patternSelect = q.patternSel;
  assign dispCfg = q.cfg;

endmodule

/* char_disp_decoder_props.sv */
// concurrent checks on the decoder ports
`timescale 1ns/1ps
module char_disp_decoder_props #(
  parameter int CLEAR_CYCLES = 200
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic instrDataSelect,
  input wire logic wrStrobe,
  input wire logic rdStrobe,
  input wire logic [7:0] wrData,
  input wire logic [7:0] rdData,
  input wire logic busyFlag,
  input wire logic [6:0] addressCounter,
  input wire logic patternSelect,
  input wire char_disp_pkg::dispCfg_t dispCfg
);
  // ********
  // checks
  // ********
  localparam int CLR = CLEAR_CYCLES - 1;
  logic insWr;
  logic [7:0] lastWr;
  assign insWr = wrStrobe && !busyFlag && !instrDataSelect;
  always_ff @(posedge clk_sys) begin
    lastWr <= wrData;
  end
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);

  clear_run_a: assert property (
    insWr && wrData == 8'h01 |=> addressCounter == 7'h00 && busyFlag
    ##CLR busyFlag ##1 !busyFlag) else $error("clear timing wrong");
  exec_time_a: assert property (
    wrStrobe && !busyFlag && wrData > 8'h01 |=>
    busyFlag [*8] ##[74:153] !busyFlag) else $error("busy time wrong");
  status_read_a: assert property (
    rdStrobe && !instrDataSelect |=>
    rdData == {$past(busyFlag), $past(addressCounter)})
    else $error("status read wrong");
  refuse_write_a: assert property (
    busyFlag && wrStrobe ##1 busyFlag |-> $stable(dispCfg)
    && $stable(addressCounter) && $stable(patternSelect))
    else $error("write taken while busy");
  refuse_read_a: assert property (
    busyFlag && rdStrobe && instrDataSelect |=> rdData == 8'h00)
    else $error("data read taken while busy");
  entry_mode_a: assert property (
    insWr && wrData[7:2] == 6'h01 |=>
    {dispCfg.entryInc, dispCfg.entryShift} == lastWr[1:0])
    else $error("entry mode not stored");
  disp_ctl_a: assert property (
    insWr && wrData[7:3] == 5'h01 |=> {dispCfg.displayOn,
    dispCfg.cursorOn, dispCfg.blinkOn} == lastWr[2:0])
    else $error("display control not stored");
  mode_pwr_a: assert property (
    insWr && wrData[7:4] == 4'h1 && wrData[1:0] == 2'h3 |=>
    {dispCfg.graphicMode, dispCfg.powerOn} == lastWr[3:2])
    else $error("mode bits not stored");
  func_set_a: assert property (
    insWr && wrData[7:5] == 3'h1 |=> {dispCfg.busWidthSelect,
    dispCfg.lineCount, dispCfg.fontSel, dispCfg.fontTableHi,
    dispCfg.fontTableLo} == lastWr[4:0]) else $error("function set lost");
  addr_set_a: assert property (
    insWr && wrData[7:6] != 2'h0 |=> patternSelect == !lastWr[7] &&
    addressCounter == (lastWr[7] ? lastWr[6:0] : {1'b0, lastWr[5:0]}))
    else $error("address set wrong");
  home_a: assert property (
    insWr && wrData[7:1] == 7'h01 |=> addressCounter == 7'h00
    && dispCfg.shiftOffset == 7'h00) else $error("return home wrong");
endmodule

bind char_disp_decoder char_disp_decoder_props #(
  .CLEAR_CYCLES(CLEAR_CYCLES)
) props_inst (.clk_sys(clk_sys), .rstn(rstn),
  .instrDataSelect(instrDataSelect), .wrStrobe(wrStrobe),
  .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData),
  .busyFlag(busyFlag), .addressCounter(addressCounter),
  .patternSelect(patternSelect), .dispCfg(dispCfg));

/* char_disp_pkg.sv */
// shared constants, types and decode helpers of the character display decoder
package char_disp_pkg;

  // ***************************************************************
  // clocking and timing
  // ***************************************************************
  localparam int CLK_FREQ_HZ = 20000000;
  localparam int OSC_FREQ_HZ = 250000;
  localparam int OSC_DIV = CLK_FREQ_HZ / OSC_FREQ_HZ;
  localparam int CLEAR_TIME_US = 6200;
  // longest time: rounded down
  localparam int CLEAR_CYCLES = CLEAR_TIME_US * (CLK_FREQ_HZ / 1000000);
  localparam int EXEC_TICKS = 2;
  localparam int CNT_W = 24;

  // ***************************************************************
  // memory layout
  // ***************************************************************
  localparam int DISP_AW = 7;
  localparam int PAT_AW = 6;
  localparam int MEM_AW = 8;
  localparam int DATA_W = 8;
  localparam logic [7:0] BLANK_CODE = 8'h20;
  localparam logic [6:0] DISP_TOP = 7'h7F;

  // ***************************************************************
  // instruction fields
  // ***************************************************************
  localparam int OP_CLEAR = 0;
  localparam int OP_HOME = 1;
  localparam int OP_ENTRY = 2;
  localparam int OP_DISPCTL = 3;
  localparam int OP_SHIFT = 4;
  localparam int OP_FUNC = 5;
  localparam int OP_PATADDR = 6;
  localparam int OP_DISPADDR = 7;
  localparam logic [3:0] OP_NONE = 4'h8;
  localparam int ENTRY_ID_BIT = 1;
  localparam int ENTRY_S_BIT = 0;
  localparam int DISP_ON_BIT = 2;
  localparam int CUR_ON_BIT = 1;
  localparam int BLINK_BIT = 0;
  localparam int SHIFT_SC_BIT = 3;
  localparam int SHIFT_RL_BIT = 2;
  localparam int MODE_GC_BIT = 3;
  localparam int MODE_PWR_BIT = 2;
  localparam int FS_DL_BIT = 4;
  localparam int FS_N_BIT = 3;
  localparam int FS_F_BIT = 2;
  localparam int FS_FTHI_BIT = 1;
  localparam int FS_FTLO_BIT = 0;
  localparam logic [1:0] SUB_SHIFT = 2'h0;
  localparam logic [1:0] SUB_MODE = 2'h3;

  // ***************************************************************
  // values after reset
  // ***************************************************************
  localparam logic RST_ENTRY_INC = 1'b1;
  localparam logic RST_BUS_WIDTH = 1'b1;
  localparam logic RST_POWER_ON = 1'b1;

  // ***************************************************************
  // types
  // ***************************************************************
  typedef struct packed {
    logic entryInc;
    logic entryShift;
    logic displayOn;
    logic cursorOn;
    logic blinkOn;
    logic graphicMode;
    logic powerOn;
    logic busWidthSelect;
    logic lineCount;
    logic fontSel;
    logic fontTableHi;
    logic fontTableLo;
    logic [DISP_AW-1:0] shiftOffset;
  } dispCfg_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CLEAR = 3'b010,
    ST_EXEC = 3'b100
  } decState_t;

  typedef struct packed {
    decState_t st;
    dispCfg_t cfg;
    logic [DISP_AW-1:0] addressCounter;
    logic patternSel;
    logic busyFlag;
    logic [DATA_W-1:0] rdData;
    logic [CNT_W-1:0] cnt;
    logic [DISP_AW-1:0] clrAddr;
    logic clrDone;
    logic pendStep;
    logic pendShift;
  } decRegs_t;

  // position of the highest set bit, OP_NONE for zero
  function automatic logic [3:0] msbPos(input logic [7:0] b);
    logic [3:0] p;
    p = OP_NONE;
    for (int i = 0; i < 8; i++) begin
      if (b[i]) begin
        p = 4'(i);
      end
    end
    return p;
  endfunction

endpackage

/* disp_mem.sv */
// byte memory holding display and pattern data, registered read
`timescale 1ns/1ps
module disp_mem #(
  parameter int AW = char_disp_pkg::MEM_AW,
  parameter int DW = char_disp_pkg::DATA_W
) (
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic we,
  input wire logic [AW-1:0] wAddr,
  input wire logic [DW-1:0] wData,
  input wire logic [AW-1:0] rAddr,
  output logic [DW-1:0] rData
);

  logic [DW-1:0] mem [0:(1<<AW)-1];

  always_ff @(posedge clk_sys) begin
    if (we) begin
      mem[wAddr] <= wData;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      rData <= '0;
    end else begin
      rData <= mem[rAddr];
    end
  end

endmodule

/* host_model.sv */
// host processor model driving the decoder access port
`timescale 1ns/1ps
module host_model (
  input wire logic clk_sys,
  output logic instrDataSelect,
  output logic wrStrobe,
  output logic rdStrobe,
  output logic [7:0] wrData,
  input wire logic [7:0] rdData
);
  // ********
  // bus cycles
  // ********
  initial begin
    instrDataSelect = 1'b0;
    wrStrobe = 1'b0;
    rdStrobe = 1'b0;
    wrData = 8'h00;
  end
  // released data line shows the inverse of the last byte
  task automatic wr(input logic sel, input logic [7:0] b);
    @(posedge clk_sys);
    instrDataSelect <= sel;
    wrStrobe <= 1'b1;
    wrData <= (!sel && b[7:1] == 7'h01) ? 8'h02 : b;
    @(posedge clk_sys);
    wrStrobe <= 1'b0;
    wrData <= ~b;
  endtask
  task automatic rd(input logic sel, output logic [7:0] b);
    @(posedge clk_sys);
    instrDataSelect <= sel;
    rdStrobe <= 1'b1;
    @(posedge clk_sys);
    rdStrobe <= 1'b0;
    #1 b = rdData;
  endtask
  // polls status until the busy bit reads low or 300 reads have been made
  task automatic waitIdle(output logic [7:0] st);
    st = 8'hFF;
    for (int i = 0; i < 300 && st[7] !== 1'b0; i++) begin
      rd(1'b0, st);
    end
  endtask
endmodule

/* osc_tick.sv */
// divider giving a one-cycle enable at the internal oscillator rate
`timescale 1ns/1ps
module osc_tick #(
  parameter int DIV = char_disp_pkg::OSC_DIV
) (
  input wire logic clk_sys,
  input wire logic rstn,
  output logic tick
);

  typedef struct packed {
    logic [15:0] cnt;
    logic tick;
  } tickRegs_t;

  tickRegs_t q;
  tickRegs_t d;

  always_comb begin
    d = q;
    d.tick = 1'b0;
    if (q.cnt == 16'(DIV - 1)) begin
      d.cnt = 16'h0000;
      d.tick = 1'b1;
    end else begin
      d.cnt = q.cnt + 16'h0001;
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  assign tick = q.tick;

endmodule

/* tb_char_disp_decoder.sv */
// self-checking bench of the character display decoder
`timescale 1ns/1ps
module tb_char_disp_decoder;
  // ********
  // wiring
  // ********
  logic clk_sys;
  logic rstn;
  logic instrDataSelect;
  logic wrStrobe;
  logic rdStrobe;
  logic [7:0] wrData;
  logic [7:0] rdData;
  logic busyFlag;
  logic [6:0] addressCounter;
  logic patternSelect;
  char_disp_pkg::dispCfg_t dispCfg;
  int error_cnt = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [7:0] v;

  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end

  char_disp_decoder #(.CLEAR_CYCLES(200), .EXEC_TICKS(2))
  char_disp_decoder_inst (.clk_sys(clk_sys), .rstn(rstn),
    .instrDataSelect(instrDataSelect), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData),
    .busyFlag(busyFlag), .addressCounter(addressCounter),
    .patternSelect(patternSelect), .dispCfg(dispCfg));
  host_model host_model_inst (.clk_sys(clk_sys),
    .instrDataSelect(instrDataSelect), .wrStrobe(wrStrobe),
    .rdStrobe(rdStrobe), .wrData(wrData), .rdData(rdData));

  // ********
  // helpers
  // ********
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    comparisons++;
    if (g !== e) begin
      error_cnt++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic conclude;
    $display("counts: %0d compares, %0d mismatches", comparisons, error_cnt);
    if (error_cnt == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // write then poll; v ends as the status byte
  task automatic ins(input logic [7:0] b);
    host_model_inst.wr(1'b0, b);
    host_model_inst.waitIdle(v);
  endtask
  task automatic dat(input logic [7:0] b);
    host_model_inst.wr(1'b1, b);
    host_model_inst.waitIdle(v);
  endtask
  task automatic rdDat(input logic [7:0] e);
    host_model_inst.rd(1'b1, v);
    chk(v, e);
    host_model_inst.waitIdle(v);
  endtask

  always @(posedge clk_sys) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      error_cnt++;
      $display("mismatch at %0t: run timed out", $time);
      conclude();
    end
  end

  // ********
  // tests
  // ********
  initial begin
    rstn = 1'b0;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    @(posedge clk_sys);
    #1;
    chk(dispCfg[18:11], 8'h83);
    chk({4'h0, dispCfg[10:7]}, 8'h00);
    host_model_inst.waitIdle(v);
    chk(v, 8'h00);
    $display("test reset done");
    ins(8'h85);
    chk(v, 8'h05);
    dat(8'h41);
    chk(v, 8'h06);
    ins(8'h01);
    chk(v, 8'h00);
    ins(8'h85);
    rdDat(char_disp_pkg::BLANK_CODE);
    chk(v, 8'h06);
    $display("test clear done");
    ins(8'h05);
    ins(8'h90);
    dat(8'h41);
    chk(v, 8'h0F);
    chk({1'b0, dispCfg.shiftOffset}, 8'h7F);
    ins(8'h04);
    dat(8'h42);
    chk(v, 8'h0E);
    chk({1'b0, dispCfg.shiftOffset}, 8'h7F);
    ins(8'h03);
    chk(v, 8'h00);
    chk({1'b0, dispCfg.shiftOffset}, 8'h00);
    ins(8'h90);
    rdDat(8'h41);
    ins(8'h05);
    rdDat(8'h42);
    chk(v, 8'h0E);
    chk({1'b0, dispCfg.shiftOffset}, 8'h7F);
    ins(8'h02);
    $display("test entry mode done");
    ins(8'h06);
    ins(8'h43);
    chk(v, 8'h03);
    chk({7'h00, patternSelect}, 8'h01);
    dat(8'h55);
    chk(v, 8'h04);
    ins(8'h43);
    rdDat(8'h55);
    $display("test pattern ram done");
    ins(8'h80);
    ins(8'h14);
    chk(v, 8'h01);
    ins(8'h18);
    chk({1'b0, dispCfg.shiftOffset}, 8'h7F);
    ins(8'h1C);
    chk({1'b0, dispCfg.shiftOffset}, 8'h00);
    ins(8'h0D);
    chk({5'h00, dispCfg[16:14]}, 8'h05);
    ins(8'h1B);
    chk({6'h00, dispCfg[13:12]}, 8'h02);
    ins(8'h17);
    chk({6'h00, dispCfg[13:12]}, 8'h01);
    ins(8'h2A);
    chk({3'h0, dispCfg[11:7]}, 8'h0A);
    ins(8'h35);
    chk({3'h0, dispCfg[11:7]}, 8'h15);
    $display("test config done");
    host_model_inst.wr(1'b0, 8'h0C);
    host_model_inst.wr(1'b0, 8'h08);
    host_model_inst.rd(1'b1, v);
    chk(v, 8'h00);
    host_model_inst.rd(1'b0, v);
    chk({7'h00, v[7]}, 8'h01);
    host_model_inst.waitIdle(v);
    chk({5'h00, dispCfg[16:14]}, 8'h04);
    $display("test busy refusal done");
    conclude();
  end
endmodule
